// ===== include/oteng_defines.vh
/*
  Constants for the OAM test and loopback PDU engine: register offsets,
  control bit positions, sticky bit positions, PDU type codes and reset
  values.
  Assumes it is included by bare name from the design file.
*/
`ifndef OTENG_DEFINES_VH
`define OTENG_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define OTENG_REG_CTRL      8'h00
`define OTENG_REG_MODE      8'h04
`define OTENG_REG_TX_TID    8'h08
`define OTENG_REG_RX_TID    8'h0C
`define OTENG_REG_STICKY    8'h10
`define OTENG_REG_EXTRACT   8'h14
`define OTENG_REG_RX_FRM    8'h18
`define OTENG_REG_SEQ_ERR   8'h1C
`define OTENG_REG_CRC_ERR   8'h20
`define OTENG_REG_TX_REPLY  8'h24

// ----------------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------------
`define OTENG_CTL_TST_HW       0
`define OTENG_CTL_TST_OAM_CNT  1
`define OTENG_CTL_TST_LOSS_CNT 2
`define OTENG_CTL_TST_SEQ_UPD  3
`define OTENG_CTL_TST_CPU      4
`define OTENG_CTL_TST_CRC      5
`define OTENG_CTL_LREQ_HW      6
`define OTENG_CTL_LREP_HW      7
`define OTENG_CTL_LREQ_OAM_CNT 8
`define OTENG_CTL_LREP_OAM_CNT 9
`define OTENG_CTL_LREQ_LOSS    10
`define OTENG_CTL_LREP_LOSS    11
`define OTENG_CTL_LREQ_SEQ_UPD 12
`define OTENG_CTL_LREQ_LOOP    13
`define OTENG_CTL_LREQ_CPU     14
`define OTENG_CTL_LREP_CPU     15
`define OTENG_CTL_LREP_CRC     16
`define OTENG_CTL_WIDTH        17
`define OTENG_CTL_RESET        17'h00000

// ----------------------------------------------------------------------
// mode register: active family and alternate-OAM flag
// ----------------------------------------------------------------------
`define OTENG_FAM_NONE      2'h0
`define OTENG_FAM_TEST      2'h1
`define OTENG_FAM_LOOP      2'h2
`define OTENG_FAM_SAM       2'h3
`define OTENG_MODE_ALT_BIT  2
`define OTENG_MODE_RESET    3'h0

// ----------------------------------------------------------------------
// sticky bits (write one to clear)
// ----------------------------------------------------------------------
`define OTENG_STK_TST_RX    0
`define OTENG_STK_LREQ_RX   1
`define OTENG_STK_LREP_RX   2
`define OTENG_STK_TID_ERR   3

// ----------------------------------------------------------------------
// pdu type codes on the lookup ports
// ----------------------------------------------------------------------
`define OTENG_PDU_TEST      2'h0
`define OTENG_PDU_LREQ      2'h1
`define OTENG_PDU_LREP      2'h2
`define OTENG_PDU_OTHER     2'h3

// test pattern types whose TLV carries a CRC
`define OTENG_PAT_CRC_A     8'h01
`define OTENG_PAT_CRC_B     8'h03

`define OTENG_WORD_RESET    32'h00000000

`endif

// ===== logic/oteng_top.v
/*
  OAM endpoint engine for test and loopback PDUs. One lookup per cycle
  on the transmit side and one on the receive side, each a one-cycle
  descriptor of an already validated PDU; results come back registered
  one cycle later. Registers are reached over a plain strobe port.
  Assumes the frame pipeline has validated each PDU, extracted its
  sequence number and TEST TLV fields and computed the TLV CRC.
*/
//
// Overview of operation
// R1: one PDU family active per endpoint
// R2: test hw off: stats only, no edits
// R3: oam and loss count enables per type
// R4: tx test seq overwritten with tx identifier
// R5: tx test bumps tx identifier by one
// R6: rx test sets test receive flag
// R7: rx test seq vs stored+1, error flag, count
// R8: rx test seq stored as rx identifier
// R9: valid rx frame counter increments
// R10: extract-next copies next test PDU
// R11: test copy setting copies all test PDUs
// R12: crc check only first TEST TLV
// R13: crc checked only for patterns 1, 3
// R14: sender inserts TLV and CRC itself
// R15: separate request and reply hw enables
// R16: tx request gets identifier, then +1
// R17: rx request flag, loop back a reply
// R18: count transmitted replies
// R19: rx reply flag, seq check, store
// R20: mismatched reply still valid and counted
// R21: request/reply copy, extract-next for reply
// R22: reply crc check, not in alternate mode
// R23: extract-next clears after one copy
// R24: identifiers 32 bits, wrap to zero
`timescale 1ns/1ps
`default_nettype none
`include "oteng_defines.vh"

module oteng_top (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output reg [31:0] reg_rdata_o,
  // transmit lookup
  input wire tx_pdu_valid_i,
  input wire [1:0] tx_pdu_type_i,
  input wire [31:0] tx_seq_i,
  output reg tx_done_o,
  output reg [31:0] tx_seq_o,
  output reg tx_seq_write_o,
  output reg tx_oam_count_o,
  output reg tx_loss_count_o,
  // receive lookup
  input wire rx_pdu_valid_i,
  input wire [1:0] rx_pdu_type_i,
  input wire [31:0] rx_seq_i,
  input wire rx_tlv_first_test_i,
  input wire [7:0] rx_tlv_pattern_i,
  input wire [31:0] rx_tlv_crc_i,
  input wire [31:0] rx_tlv_crc_calc_i,
  output reg rx_done_o,
  output reg rx_cpu_copy_o,
  output reg rx_loop_inject_o,
  output reg rx_oam_count_o,
  output reg rx_loss_count_o,
  output reg rx_crc_error_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // 32-bit increment that wraps from all ones to zero
  function [31:0] inc32;
    input [31:0] v;
    begin
      inc32 = v + 32'h00000001; // R24
    end
  endfunction

  // sticky update: hardware set wins over a software clear
  function stick;
    input q;
    input set;
    input clr;
    begin
      stick = set | (q & ~clr);
    end
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg [`OTENG_CTL_WIDTH-1:0] ctrl_q;
  reg [2:0] mode_q;
  reg [31:0] tx_tid_q;
  reg [31:0] rx_tid_q;
  reg [3:0] sticky_q;
  reg extract_q;
  reg [31:0] rx_frm_cnt_q;
  reg [31:0] seq_err_cnt_q;
  reg [31:0] crc_err_cnt_q;
  reg [31:0] tx_reply_cnt_q;

  wire wr_ctrl = reg_we_i && (reg_addr_i == `OTENG_REG_CTRL);
  wire wr_mode = reg_we_i && (reg_addr_i == `OTENG_REG_MODE);
  wire wr_txt = reg_we_i && (reg_addr_i == `OTENG_REG_TX_TID);
  wire wr_rxt = reg_we_i && (reg_addr_i == `OTENG_REG_RX_TID);
  wire wr_stk = reg_we_i && (reg_addr_i == `OTENG_REG_STICKY);
  wire wr_ext = reg_we_i && (reg_addr_i == `OTENG_REG_EXTRACT);
  wire wr_frm = reg_we_i && (reg_addr_i == `OTENG_REG_RX_FRM);
  wire wr_ser = reg_we_i && (reg_addr_i == `OTENG_REG_SEQ_ERR);
  wire wr_cer = reg_we_i && (reg_addr_i == `OTENG_REG_CRC_ERR);
  wire wr_rep = reg_we_i && (reg_addr_i == `OTENG_REG_TX_REPLY);

  // ----------------------------------------------------------------------
  // family selection
  // ----------------------------------------------------------------------

  // test and loopback share one identifier set, so only the selected
  // family is processed; the other still gets its oam/loss counting
  wire fam_test = (mode_q[1:0] == `OTENG_FAM_TEST); // R1
  wire fam_loop = (mode_q[1:0] == `OTENG_FAM_LOOP); // R1
  wire alt_mode = mode_q[`OTENG_MODE_ALT_BIT];

  // ----------------------------------------------------------------------
  // transmit lookup
  // ----------------------------------------------------------------------
  wire tx_test = tx_pdu_valid_i && (tx_pdu_type_i == `OTENG_PDU_TEST);
  wire tx_lreq = tx_pdu_valid_i && (tx_pdu_type_i == `OTENG_PDU_LREQ);
  wire tx_lrep = tx_pdu_valid_i && (tx_pdu_type_i == `OTENG_PDU_LREP);

  // hardware processing per type, gated by the active family
  wire tx_test_hw = tx_test && fam_test && ctrl_q[`OTENG_CTL_TST_HW]; // R2
  wire tx_lreq_hw = tx_lreq && fam_loop && ctrl_q[`OTENG_CTL_LREQ_HW]; // R15
  wire tx_lrep_hw = tx_lrep && fam_loop && ctrl_q[`OTENG_CTL_LREP_HW]; // R15

  // identifier advances for each processed test or request
  wire tx_tid_adv = tx_test_hw | tx_lreq_hw; // R5 R16
  wire tx_ovr = (tx_test_hw && ctrl_q[`OTENG_CTL_TST_SEQ_UPD]) ||
                (tx_lreq_hw && ctrl_q[`OTENG_CTL_LREQ_SEQ_UPD]);

  reg tx_oam_d;
  reg tx_loss_d;
  // counting follows the per-type enables even with hardware off
  always @* begin
    tx_oam_d = 1'b0;
    tx_loss_d = 1'b0;
    case (tx_pdu_type_i)
      `OTENG_PDU_TEST: begin
        tx_oam_d = ctrl_q[`OTENG_CTL_TST_OAM_CNT]; // R3
        tx_loss_d = ctrl_q[`OTENG_CTL_TST_LOSS_CNT]; // R3
      end
      `OTENG_PDU_LREQ: begin
        tx_oam_d = ctrl_q[`OTENG_CTL_LREQ_OAM_CNT]; // R3
        tx_loss_d = ctrl_q[`OTENG_CTL_LREQ_LOSS];
      end
      `OTENG_PDU_LREP: begin
        tx_oam_d = ctrl_q[`OTENG_CTL_LREP_OAM_CNT];
        tx_loss_d = ctrl_q[`OTENG_CTL_LREP_LOSS];
      end
      default: begin
        tx_oam_d = 1'b0;
        tx_loss_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // receive lookup
  // ----------------------------------------------------------------------
  wire rx_test = rx_pdu_valid_i && (rx_pdu_type_i == `OTENG_PDU_TEST);
  wire rx_lreq = rx_pdu_valid_i && (rx_pdu_type_i == `OTENG_PDU_LREQ);
  wire rx_lrep = rx_pdu_valid_i && (rx_pdu_type_i == `OTENG_PDU_LREP);

  wire rx_test_hw = rx_test && fam_test && ctrl_q[`OTENG_CTL_TST_HW]; // R2
  wire rx_lreq_hw = rx_lreq && fam_loop && ctrl_q[`OTENG_CTL_LREQ_HW]; // R15
  wire rx_lrep_hw = rx_lrep && fam_loop && ctrl_q[`OTENG_CTL_LREP_HW]; // R15

  // test and reply both run the sequence check against stored + 1;
  // a mismatching reply stays valid and is still counted
  wire rx_chk = rx_test_hw | rx_lrep_hw; // R7 R19 R20
  wire rx_seq_bad = rx_chk && (rx_seq_i != inc32(rx_tid_q)); // R7 R19

  // crc: first TLV only, patterns with a CRC only, and never for the
  // reply in alternate mode where an id TLV must come first
  wire pat_has_crc = (rx_tlv_pattern_i == `OTENG_PAT_CRC_A) ||
                     (rx_tlv_pattern_i == `OTENG_PAT_CRC_B); // R13
  wire crc_en = (rx_test_hw && ctrl_q[`OTENG_CTL_TST_CRC]) ||
                (rx_lrep_hw && ctrl_q[`OTENG_CTL_LREP_CRC] &&
                 !alt_mode); // R12 R22
  wire crc_bad = crc_en && rx_tlv_first_test_i && pat_has_crc &&
                 (rx_tlv_crc_i != rx_tlv_crc_calc_i); // R12 R13

  // copy to cpu: per-type copy-all, or extract-next for test and reply
  wire ext_hit = extract_q && (rx_test_hw | rx_lrep_hw); // R10 R21
  wire rx_copy = (rx_test_hw && ctrl_q[`OTENG_CTL_TST_CPU]) ||
                 (rx_lreq_hw && ctrl_q[`OTENG_CTL_LREQ_CPU]) ||
                 (rx_lrep_hw && ctrl_q[`OTENG_CTL_LREP_CPU]) ||
                 ext_hit; // R11 R21

  wire rx_inject = rx_lreq_hw && ctrl_q[`OTENG_CTL_LREQ_LOOP]; // R17

  reg rx_oam_d;
  reg rx_loss_d;
  always @* begin
    rx_oam_d = 1'b0;
    rx_loss_d = 1'b0;
    case (rx_pdu_type_i)
      `OTENG_PDU_TEST: begin
        rx_oam_d = ctrl_q[`OTENG_CTL_TST_OAM_CNT]; // R3
        rx_loss_d = ctrl_q[`OTENG_CTL_TST_LOSS_CNT]; // R3
      end
      `OTENG_PDU_LREQ: begin
        rx_oam_d = ctrl_q[`OTENG_CTL_LREQ_OAM_CNT];
        rx_loss_d = ctrl_q[`OTENG_CTL_LREQ_LOSS];
      end
      `OTENG_PDU_LREP: begin
        rx_oam_d = ctrl_q[`OTENG_CTL_LREP_OAM_CNT];
        rx_loss_d = ctrl_q[`OTENG_CTL_LREP_LOSS];
      end
      default: begin
        rx_oam_d = 1'b0;
        rx_loss_d = 1'b0;
      end
    endcase
  end

  // sticky set terms
  wire [3:0] stk_set;
  assign stk_set[`OTENG_STK_TST_RX] = rx_test_hw; // R6
  assign stk_set[`OTENG_STK_LREQ_RX] = rx_lreq_hw; // R17
  assign stk_set[`OTENG_STK_LREP_RX] = rx_lrep_hw; // R19
  assign stk_set[`OTENG_STK_TID_ERR] = rx_seq_bad; // R7 R19

  // ----------------------------------------------------------------------
  // configuration and state registers
  // ----------------------------------------------------------------------

  // a same-cycle hardware update beats a software write to counters and
  // identifiers, so no event is lost to a racing write
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= `OTENG_CTL_RESET;
      mode_q <= `OTENG_MODE_RESET;
      tx_tid_q <= `OTENG_WORD_RESET;
      rx_tid_q <= `OTENG_WORD_RESET;
      sticky_q <= 4'h0;
      extract_q <= 1'b0;
      rx_frm_cnt_q <= `OTENG_WORD_RESET;
      seq_err_cnt_q <= `OTENG_WORD_RESET;
      crc_err_cnt_q <= `OTENG_WORD_RESET;
      tx_reply_cnt_q <= `OTENG_WORD_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_i[`OTENG_CTL_WIDTH-1:0];
      end
      if (wr_mode) begin
        mode_q <= reg_wdata_i[2:0];
      end
      if (tx_tid_adv) begin
        tx_tid_q <= inc32(tx_tid_q); // R5 R16 R24
      end else if (wr_txt) begin
        tx_tid_q <= reg_wdata_i;
      end
      if (rx_chk) begin
        rx_tid_q <= rx_seq_i; // R8 R19
      end else if (wr_rxt) begin
        rx_tid_q <= reg_wdata_i;
      end
      sticky_q[0] <= stick(sticky_q[0], stk_set[0], wr_stk & reg_wdata_i[0]);
      sticky_q[1] <= stick(sticky_q[1], stk_set[1], wr_stk & reg_wdata_i[1]);
      sticky_q[2] <= stick(sticky_q[2], stk_set[2], wr_stk & reg_wdata_i[2]);
      sticky_q[3] <= stick(sticky_q[3], stk_set[3], wr_stk & reg_wdata_i[3]);
      // a software request in the clearing cycle arms the next frame
      if (wr_ext && reg_wdata_i[0]) begin
        extract_q <= 1'b1;
      end else if (ext_hit) begin
        extract_q <= 1'b0; // R23
      end else if (wr_ext) begin
        extract_q <= 1'b0;
      end
      if (rx_chk) begin
        rx_frm_cnt_q <= inc32(rx_frm_cnt_q); // R9 R20
      end else if (wr_frm) begin
        rx_frm_cnt_q <= reg_wdata_i;
      end
      if (rx_seq_bad) begin
        seq_err_cnt_q <= inc32(seq_err_cnt_q); // R7 R19
      end else if (wr_ser) begin
        seq_err_cnt_q <= reg_wdata_i;
      end
      if (crc_bad) begin
        crc_err_cnt_q <= inc32(crc_err_cnt_q); // R12
      end else if (wr_cer) begin
        crc_err_cnt_q <= reg_wdata_i;
      end
      if (tx_lrep_hw) begin
        tx_reply_cnt_q <= inc32(tx_reply_cnt_q); // R18
      end else if (wr_rep) begin
        tx_reply_cnt_q <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // lookup result outputs
  // ----------------------------------------------------------------------

  // pdu contents are passed through untouched unless overwrite is set
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_done_o <= 1'b0;
      tx_seq_o <= `OTENG_WORD_RESET;
      tx_seq_write_o <= 1'b0;
      tx_oam_count_o <= 1'b0;
      tx_loss_count_o <= 1'b0;
      rx_done_o <= 1'b0;
      rx_cpu_copy_o <= 1'b0;
      rx_loop_inject_o <= 1'b0;
      rx_oam_count_o <= 1'b0;
      rx_loss_count_o <= 1'b0;
      rx_crc_error_o <= 1'b0;
    end else begin
      tx_done_o <= tx_pdu_valid_i;
      tx_seq_o <= tx_ovr ? tx_tid_q : tx_seq_i; // R4 R16 R2
      tx_seq_write_o <= tx_ovr; // R4 R16
      tx_oam_count_o <= tx_pdu_valid_i & tx_oam_d; // R3
      tx_loss_count_o <= tx_pdu_valid_i & tx_loss_d; // R3
      rx_done_o <= rx_pdu_valid_i;
      rx_cpu_copy_o <= rx_copy; // R10 R11 R21
      rx_loop_inject_o <= rx_inject; // R17
      rx_oam_count_o <= rx_pdu_valid_i & rx_oam_d; // R3
      rx_loss_count_o <= rx_pdu_valid_i & rx_loss_d; // R3
      rx_crc_error_o <= crc_bad; // R12
    end
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  reg [31:0] rd_d;
  always @* begin
    case (reg_addr_i)
      `OTENG_REG_CTRL: rd_d = {15'h0000, ctrl_q};
      `OTENG_REG_MODE: rd_d = {29'h00000000, mode_q};
      `OTENG_REG_TX_TID: rd_d = tx_tid_q;
      `OTENG_REG_RX_TID: rd_d = rx_tid_q;
      `OTENG_REG_STICKY: rd_d = {28'h0000000, sticky_q};
      `OTENG_REG_EXTRACT: rd_d = {31'h00000000, extract_q};
      `OTENG_REG_RX_FRM: rd_d = rx_frm_cnt_q;
      `OTENG_REG_SEQ_ERR: rd_d = seq_err_cnt_q;
      `OTENG_REG_CRC_ERR: rd_d = crc_err_cnt_q;
      `OTENG_REG_TX_REPLY: rd_d = tx_reply_cnt_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  // data stand for exactly the cycle after the read strobe
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= `OTENG_WORD_RESET;
    end else begin
      reg_rdata_o <= reg_re_i ? rd_d : 32'h00000000;
    end
  end

endmodule // oteng_top
`default_nettype wire

// ===== test/oteng_peer_model.sv
/*
  Peer endpoint model: delivers test and loopback PDUs to the engine's
  receive lookup, with the TEST TLV and its CRC already in place.
  Assumes the bench asks for one PDU per send pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module oteng_peer_model (
  // clock
  input wire logic clk_i,
  // commands from the bench
  input wire logic send_i,
  input wire logic [1:0] type_i,
  input wire logic [31:0] seq_i,
  input wire logic [7:0] pattern_i,
  input wire logic first_i,
  input wire logic bad_crc_i,
  // descriptor toward the engine
  output logic rx_pdu_valid_o,
  output logic [1:0] rx_pdu_type_o,
  output logic [31:0] rx_seq_o,
  output logic rx_tlv_first_test_o,
  output logic [7:0] rx_tlv_pattern_o,
  output logic [31:0] rx_tlv_crc_o,
  output logic [31:0] rx_tlv_crc_calc_o
);
  localparam logic [31:0] crc_key = 32'h5A5A0F0F;

  // the sender builds the tlv and crc, the engine only checks them;
  // between frames every field toggles so stale data cannot pass
  always @(posedge clk_i) begin
    rx_pdu_valid_o <= send_i;
    if (send_i) begin
      rx_pdu_type_o <= type_i;
      rx_seq_o <= seq_i;
      rx_tlv_first_test_o <= first_i;
      rx_tlv_pattern_o <= pattern_i;
      rx_tlv_crc_o <= seq_i ^ crc_key;
      rx_tlv_crc_calc_o <= seq_i ^ crc_key ^ {31'h0, bad_crc_i};
    end else begin
      rx_pdu_type_o <= ~rx_pdu_type_o;
      rx_seq_o <= ~rx_seq_o;
      rx_tlv_first_test_o <= ~rx_tlv_first_test_o;
      rx_tlv_pattern_o <= ~rx_tlv_pattern_o;
      rx_tlv_crc_o <= ~rx_tlv_crc_o;
      rx_tlv_crc_calc_o <= ~rx_tlv_crc_calc_o;
    end
  end
endmodule // oteng_peer_model
`default_nettype wire

// ===== test/oteng_top_sva.sv
/*
  Checker for the OAM test and loopback engine: lookup answer timing, sequence overwrite, loop inject and crc error causes.
  Assumes it is bound to oteng_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "oteng_defines.vh"

module oteng_top_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // transmit lookup
  input wire logic tx_pdu_valid_i,
  input wire logic [1:0] tx_pdu_type_i,
  input wire logic [31:0] tx_seq_i,
  input wire logic tx_done_o,
  input wire logic [31:0] tx_seq_o,
  input wire logic tx_seq_write_o,
  // receive lookup
  input wire logic rx_pdu_valid_i,
  input wire logic [1:0] rx_pdu_type_i,
  input wire logic rx_tlv_first_test_i,
  input wire logic [7:0] rx_tlv_pattern_i,
  input wire logic [31:0] rx_tlv_crc_i,
  input wire logic [31:0] rx_tlv_crc_calc_i,
  input wire logic rx_done_o,
  input wire logic rx_loop_inject_o,
  input wire logic rx_crc_error_o
);
  // ---------------------------------------------------------------
  // one clock domain, so clock and reset are given once
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  // every lookup answers exactly one cycle later, never unasked
  tx_done_a: assert property (tx_done_o == $past(tx_pdu_valid_i))
    else $error("tx answer not one cycle after request");
  rx_done_a: assert property (rx_done_o == $past(rx_pdu_valid_i))
    else $error("rx answer not one cycle after request");
  // an untouched pdu keeps the sequence it came with
  tx_pass_a: assert property (tx_done_o && !tx_seq_write_o |->
    tx_seq_o == $past(tx_seq_i)) else $error("unedited seq changed");
  // back to back overwrites take consecutive identifiers, wrapping
  tx_incr_a: assert property (tx_seq_write_o ##1 tx_seq_write_o |->
    tx_seq_o == $past(tx_seq_o) + 32'h1) else $error("tx id not +1");
  // replies are counted on transmit, never renumbered
  seq_write_a: assert property (tx_seq_write_o |-> tx_done_o &&
    $past(tx_pdu_type_i) != `OTENG_PDU_LREP) else $error("bad overwrite");
  // only a received request is looped back
  loop_inject_a: assert property (rx_loop_inject_o |-> rx_done_o &&
    $past(rx_pdu_type_i) == `OTENG_PDU_LREQ) else $error("bad inject");
  // a crc error needs a leading tlv whose crc really differs
  crc_cause_a: assert property (rx_crc_error_o |->
    $past(rx_tlv_first_test_i) && $past(rx_tlv_crc_i) !=
    $past(rx_tlv_crc_calc_i)) else $error("crc error without cause");
  crc_pattern_a: assert property (rx_crc_error_o |->
    $past(rx_tlv_pattern_i) == `OTENG_PAT_CRC_A ||
    $past(rx_tlv_pattern_i) == `OTENG_PAT_CRC_B)
    else $error("crc checked on wrong pattern");
endmodule // oteng_top_sva

bind oteng_top oteng_top_sva sva (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .tx_pdu_valid_i(tx_pdu_valid_i),
  .tx_pdu_type_i(tx_pdu_type_i), .tx_seq_i(tx_seq_i),
  .tx_done_o(tx_done_o), .tx_seq_o(tx_seq_o),
  .tx_seq_write_o(tx_seq_write_o), .rx_pdu_valid_i(rx_pdu_valid_i),
  .rx_pdu_type_i(rx_pdu_type_i), .rx_tlv_first_test_i(rx_tlv_first_test_i),
  .rx_tlv_pattern_i(rx_tlv_pattern_i), .rx_tlv_crc_i(rx_tlv_crc_i),
  .rx_tlv_crc_calc_i(rx_tlv_crc_calc_i), .rx_done_o(rx_done_o),
  .rx_loop_inject_o(rx_loop_inject_o), .rx_crc_error_o(rx_crc_error_o)
);
`default_nettype wire

// ===== test/test_oteng_top.sv
/*
  Self-checking bench for the OAM test and loopback engine.
  Assumes the peer model feeds the receive lookup; checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
`include "oteng_defines.vh"

module test_oteng_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ty;
    logic [31:0] seq;
    logic [7:0] pat;
    logic first;
    logic bad;
    logic [3:0] exp;
  } oteng_row_t;
  oteng_row_t rows [6];
  int bad_count = 0;
  int compares = 0;
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'h0;
  logic reg_re_i = 1'h0;
  logic tx_pdu_valid_i = 1'h0;
  logic [1:0] tx_pdu_type_i = 2'h0;
  logic [31:0] tx_seq_i = 32'h0;
  logic send = 1'h0;
  oteng_row_t cmd = '0;
  logic [31:0] reg_rdata_o, tx_seq_o, rx_seq_i, crc_i, crc_calc_i;
  logic [7:0] pat_i;
  logic [1:0] rx_ty_i;
  logic tx_done_o, tx_seq_write_o, tx_oam_count_o, tx_loss_count_o;
  logic rx_pdu_valid_i, first_i, rx_done_o, rx_cpu_copy_o;
  logic rx_loop_inject_o, rx_oam_count_o, rx_loss_count_o, rx_crc_error_o;

  oteng_top dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .tx_pdu_valid_i(tx_pdu_valid_i),
    .tx_pdu_type_i(tx_pdu_type_i), .tx_seq_i(tx_seq_i),
    .tx_done_o(tx_done_o), .tx_seq_o(tx_seq_o),
    .tx_seq_write_o(tx_seq_write_o), .tx_oam_count_o(tx_oam_count_o),
    .tx_loss_count_o(tx_loss_count_o), .rx_pdu_valid_i(rx_pdu_valid_i),
    .rx_pdu_type_i(rx_ty_i), .rx_seq_i(rx_seq_i),
    .rx_tlv_first_test_i(first_i), .rx_tlv_pattern_i(pat_i),
    .rx_tlv_crc_i(crc_i), .rx_tlv_crc_calc_i(crc_calc_i),
    .rx_done_o(rx_done_o), .rx_cpu_copy_o(rx_cpu_copy_o),
    .rx_loop_inject_o(rx_loop_inject_o), .rx_oam_count_o(rx_oam_count_o),
    .rx_loss_count_o(rx_loss_count_o), .rx_crc_error_o(rx_crc_error_o)
  );

  oteng_peer_model peer (
    .clk_i(clk_i), .send_i(send), .type_i(cmd.ty), .seq_i(cmd.seq),
    .pattern_i(cmd.pat), .first_i(cmd.first), .bad_crc_i(cmd.bad),
    .rx_pdu_valid_o(rx_pdu_valid_i), .rx_pdu_type_o(rx_ty_i),
    .rx_seq_o(rx_seq_i), .rx_tlv_first_test_o(first_i),
    .rx_tlv_pattern_o(pat_i), .rx_tlv_crc_o(crc_i),
    .rx_tlv_crc_calc_o(crc_calc_i)
  );

  // ---------------------------------------------------------------
  // clock, shared tasks
  // ---------------------------------------------------------------
  initial forever #2.5 clk_i = ~clk_i;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'h1;
    @(posedge clk_i);
    reg_we_i <= 1'h0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'h1;
    @(posedge clk_i);
    reg_re_i <= 1'h0;
    #1;
    chk({8'h0, reg_rdata_o}, {8'h0, e});
  endtask

  // n pdus back to back; the last one's outputs stand
  task automatic tx(input logic [1:0] t, input logic [31:0] s, input int n);
    @(posedge clk_i);
    tx_pdu_valid_i <= 1'h1;
    tx_pdu_type_i <= t;
    tx_seq_i <= s;
    repeat (n) @(posedge clk_i);
    tx_pdu_valid_i <= 1'h0;
    #1;
  endtask

  // peer launches one pdu; answer is {done, copy, inject, crc error}
  task automatic rxc(input oteng_row_t r);
    @(posedge clk_i);
    cmd <= r;
    send <= 1'h1;
    @(posedge clk_i);
    send <= 1'h0;
    @(posedge clk_i);
    #1;
    chk({36'h0, rx_done_o, rx_cpu_copy_o, rx_loop_inject_o,
      rx_crc_error_o}, {36'h0, r.exp});
  endtask

  task automatic test_done;
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count = bad_count + 1;
    test_done();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    rows = '{'{2'h0, 32'h1, 8'h01, 1'h1, 1'h0, 4'h8},
      '{2'h0, 32'h2, 8'h01, 1'h1, 1'h1, 4'h9},
      '{2'h0, 32'h3, 8'h02, 1'h1, 1'h1, 4'h8},
      '{2'h0, 32'h4, 8'h03, 1'h1, 1'h1, 4'h9},
      '{2'h0, 32'h6, 8'h03, 1'h0, 1'h1, 4'h8},
      '{2'h0, 32'h7, 8'h03, 1'h1, 1'h0, 4'h8}};
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'h1;
    wr(`OTENG_REG_MODE, {30'h0, `OTENG_FAM_TEST});
    wr(`OTENG_REG_CTRL, 32'h23);
    foreach (rows[i]) rxc(rows[i]);
    rd(`OTENG_REG_RX_FRM, 32'h6);
    rd(`OTENG_REG_SEQ_ERR, 32'h1);
    rd(`OTENG_REG_CRC_ERR, 32'h2);
    rd(`OTENG_REG_RX_TID, 32'h7);
    rd(`OTENG_REG_STICKY, 32'h9);
    wr(`OTENG_REG_EXTRACT, 32'h1);
    rxc('{2'h0, 32'h8, 8'h00, 1'h0, 1'h0, 4'hC});
    rxc('{2'h0, 32'h9, 8'h00, 1'h0, 1'h0, 4'h8});
    rd(`OTENG_REG_EXTRACT, 32'h0);
    wr(`OTENG_REG_CTRL, 32'h33);
    rxc('{2'h0, 32'hA, 8'h00, 1'h0, 1'h0, 4'hC});
    wr(`OTENG_REG_CTRL, 32'h6);
    rxc('{2'h0, 32'h63, 8'h00, 1'h0, 1'h0, 4'h8});
    chk({38'h0, rx_oam_count_o, rx_loss_count_o}, 40'h3);
    rd(`OTENG_REG_RX_FRM, 32'h9);
    rd(`OTENG_REG_RX_TID, 32'hA);
    wr(`OTENG_REG_TX_TID, 32'hFFFFFFFF);
    wr(`OTENG_REG_CTRL, 32'hD);
    tx(`OTENG_PDU_TEST, 32'h55, 2);
    chk({tx_done_o, tx_seq_write_o, tx_seq_o}, {2'h3, 32'h0});
    chk({38'h0, tx_oam_count_o, tx_loss_count_o}, 40'h1);
    rd(`OTENG_REG_TX_TID, 32'h1);
    wr(`OTENG_REG_MODE, {30'h0, `OTENG_FAM_LOOP});
    wr(`OTENG_REG_STICKY, 32'hF);
    wr(`OTENG_REG_CTRL, 32'h72C0);
    rxc('{2'h2, 32'h77, 8'h00, 1'h0, 1'h0, 4'h8});
    rd(`OTENG_REG_RX_FRM, 32'hA);
    rd(`OTENG_REG_SEQ_ERR, 32'h2);
    rxc('{2'h1, 32'h0, 8'h00, 1'h0, 1'h0, 4'hE});
    rxc('{2'h0, 32'h78, 8'h00, 1'h0, 1'h0, 4'h8});
    rd(`OTENG_REG_STICKY, 32'hE);
    tx(`OTENG_PDU_LREP, 32'h31, 1);
    chk({tx_done_o, tx_seq_write_o, tx_seq_o}, {2'h2, 32'h31});
    chk({38'h0, tx_oam_count_o, tx_loss_count_o}, 40'h2);
    rd(`OTENG_REG_TX_REPLY, 32'h1);
    tx(`OTENG_PDU_LREQ, 32'h0, 1);
    chk({tx_done_o, tx_seq_write_o, tx_seq_o}, {2'h3, 32'h1});
    rd(`OTENG_REG_TX_TID, 32'h2);
    wr(`OTENG_REG_CTRL, 32'h180C0);
    rxc('{2'h2, 32'h78, 8'h01, 1'h1, 1'h1, 4'hD});
    wr(`OTENG_REG_MODE, 32'h6);
    rxc('{2'h2, 32'h79, 8'h01, 1'h1, 1'h1, 4'hC});
    // mid-run reset returns ctrl, mode and the rx frame counter to zero
    @(posedge clk_i);
    arst_n_i <= 1'h0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'h1;
    rd(`OTENG_REG_CTRL, 32'h0);
    rd(`OTENG_REG_MODE, 32'h0);
    rd(`OTENG_REG_RX_FRM, 32'h0);
    rd(8'h30, 32'h0);
    test_done();
  end
endmodule // test_oteng_top
`default_nettype wire
